// *** core/ccm_pkg.sv ***
// Constants and types for the clock mode configuration block.
package ccm_pkg;

	localparam logic [16:0] CLOCK_CONTROL_OFFSET     = 17'h1_0c80;
	localparam logic [16:0] CLOCK_MODE_STATUS_OFFSET = 17'h1_0c88;

	// Field positions as little-endian indices; bit n of the word is index n.
	localparam int BAUD_LSB        = 0;
	localparam int CLOCK_OUTPUT_DIS_BIT  = 4;
	localparam int CORE_PDF_LSB    = 28;
	localparam int CORE_MF_LSB     = 24;
	localparam int BUS_DF_LSB      = 20;
	localparam int CPM_DF_LSB      = 16;
	localparam int SYSTEM_PLL_PDF_LSB    = 12;
	localparam int SYSTEM_PLL_MF_LSB     = 8;
	localparam int DLL_DIS_BIT     = 6;
	localparam int CORE_DF_LSB     = 0;

	localparam logic [31:0] MODE_USED_MASK  = 32'hffff_ff4f;
	localparam logic [1:0]  BAUD_RESET      = 2'h1;
	localparam logic        CLOCK_OUTPUT_DIS_RESET = 1'b0;
	localparam logic [7:0]  SERIAL_CTRL_DF  = 8'h04;
	localparam logic [31:0] DEFAULT_MODE_WORD = 32'h0511_0500;

	typedef struct packed {
		logic [7:0] core_pll_prediv;
		logic [7:0] core_pll_multiplier;
		logic [7:0] bus_divide_factor;
		logic [7:0] comm_processor_divide_factor;
		logic [7:0] system_pll_prediv;
		logic [7:0] system_pll_multiplier;
		logic [7:0] core_divide_factor;
		logic       delay_loop_disable;
	} ccm_factors_t;

	typedef struct packed {
		logic        captured;
		logic [5:0]  clock_mode;
		logic [31:0] mode_word;
		ccm_factors_t factors;
		logic [1:0]  baud_clock_divider;
		logic        clock_output_disable;
		logic [8:0]  baud_divide_factor;
		logic [31:0] rdata;
	} ccm_state_t;

endpackage : ccm_pkg

// *** core/ccm_clock_mode_config.sv ***
// Clock mode capture, mode status register and clock control register.
`timescale 1ns/10ps
module ccm_code_decode #(
	parameter logic [3:0] LO     = 4'h0,
	parameter logic [3:0] HI     = 4'hf,
	parameter bit         DOUBLE = 1'b0
) (
	input  wire logic [3:0] i_code,
	output logic      [7:0] o_factor
);

	logic       in_range;
	logic [7:0] widened;

	// An unused code gives a zero factor, so no PLL is ever handed an illegal setting.
	always_comb begin
		in_range = (i_code >= LO) && (i_code <= HI);
		widened  = {4'h0, i_code};
		if (!in_range) begin
			o_factor = 8'h00;
		end else if (DOUBLE) begin
			o_factor = {widened[6:0], 1'b0};
		end else begin
			o_factor = widened + 8'h01;
		end
	end

endmodule : ccm_code_decode

module ccm_clock_mode_config #(
	parameter logic [31:0] MODE_TABLE [64] = '{default: ccm_pkg::DEFAULT_MODE_WORD}
) (
	input  wire logic                 i_clock,
	input  wire logic                 i_rst,
	input  wire logic [2:0]           i_clock_mode_pins,
	input  wire logic [2:0]           i_reset_word_clock_mode_bits,
	input  wire logic                 i_reg_sel,
	input  wire logic                 i_reg_wr,
	input  wire logic [16:0]          i_reg_addr,
	input  wire logic [31:0]          i_reg_wdata,
	output logic      [31:0]          o_reg_rdata,
	output logic                      o_mode_valid,
	output logic      [5:0]           o_clock_mode,
	output ccm_pkg::ccm_factors_t     o_factors,
	output logic      [7:0]           o_serial_ctrl_divide_factor,
	output logic      [8:0]           o_baud_divide_factor,
	output logic                      o_clock_output_enable
);

	ccm_pkg::ccm_state_t state_reg;
	ccm_pkg::ccm_state_t state_next;

	logic [5:0]            sampled_mode;
	logic [31:0]           table_word;
	logic [7:0]            core_pdf_dec;
	logic [7:0]            core_mf_dec;
	logic [7:0]            bus_df_dec;
	logic [7:0]            cpm_df_dec;
	logic [7:0]            system_pll_pdf_dec;
	logic [7:0]            system_pll_mf_dec;
	logic [7:0]            core_df_dec;
	ccm_pkg::ccm_factors_t decoded;
	logic                  ctl_hit;
	logic                  sts_hit;
	logic                  ctl_write;
	logic [1:0]            next_divider;
	logic [8:0]            baud_factor;
	logic [31:0]           read_word;

	// The table turns the six-bit mode into the full status word; reserved bits are masked.
	assign sampled_mode = {i_clock_mode_pins, i_reset_word_clock_mode_bits};
	assign table_word   = MODE_TABLE[sampled_mode] & ccm_pkg::MODE_USED_MASK;

	assign ctl_hit   = i_reg_sel && (i_reg_addr == ccm_pkg::CLOCK_CONTROL_OFFSET);
	assign sts_hit   = i_reg_sel && (i_reg_addr == ccm_pkg::CLOCK_MODE_STATUS_OFFSET);
	assign ctl_write = ctl_hit && i_reg_wr;

	// One decoder per four-bit mode field.
	ccm_code_decode #(
		.LO     (4'h0),
		.HI     (4'h3),
		.DOUBLE (1'b0)
	) u_core_pdf (
		.i_code   (table_word[ccm_pkg::CORE_PDF_LSB +: 4]),
		.o_factor (core_pdf_dec)
	);

	ccm_code_decode #(
		.LO     (4'h5),
		.HI     (4'h7),
		.DOUBLE (1'b1)
	) u_core_mf (
		.i_code   (table_word[ccm_pkg::CORE_MF_LSB +: 4]),
		.o_factor (core_mf_dec)
	);

	ccm_code_decode #(
		.LO     (4'h1),
		.HI     (4'h5),
		.DOUBLE (1'b0)
	) u_bus_df (
		.i_code   (table_word[ccm_pkg::BUS_DF_LSB +: 4]),
		.o_factor (bus_df_dec)
	);

	ccm_code_decode #(
		.LO     (4'h0),
		.HI     (4'h2),
		.DOUBLE (1'b0)
	) u_cpm_df (
		.i_code   (table_word[ccm_pkg::CPM_DF_LSB +: 4]),
		.o_factor (cpm_df_dec)
	);

	ccm_code_decode #(
		.LO     (4'h0),
		.HI     (4'h5),
		.DOUBLE (1'b0)
	) u_system_pll_pdf (
		.i_code   (table_word[ccm_pkg::SYSTEM_PLL_PDF_LSB +: 4]),
		.o_factor (system_pll_pdf_dec)
	);

	ccm_code_decode #(
		.LO     (4'h5),
		.HI     (4'hf),
		.DOUBLE (1'b1)
	) u_system_pll_mf (
		.i_code   (table_word[ccm_pkg::SYSTEM_PLL_MF_LSB +: 4]),
		.o_factor (system_pll_mf_dec)
	);

	ccm_code_decode #(
		.LO     (4'h0),
		.HI     (4'h5),
		.DOUBLE (1'b0)
	) u_core_df (
		.i_code   (table_word[ccm_pkg::CORE_DF_LSB +: 4]),
		.o_factor (core_df_dec)
	);

	// Gather the field decoders into the factor bundle that the PLL controls take.
	always_comb begin
		decoded                              = '0;
		decoded.core_pll_prediv              = core_pdf_dec;
		decoded.core_pll_multiplier          = core_mf_dec;
		decoded.bus_divide_factor            = bus_df_dec;
		decoded.comm_processor_divide_factor = cpm_df_dec;
		decoded.system_pll_prediv            = system_pll_pdf_dec;
		decoded.system_pll_multiplier        = system_pll_mf_dec;
		decoded.core_divide_factor           = core_df_dec;
		decoded.delay_loop_disable           = table_word[ccm_pkg::DLL_DIS_BIT];
	end

	// The divide factor follows the divider code on the same edge as the write lands.
	always_comb begin
		next_divider = state_reg.baud_clock_divider;
		if (ctl_write) begin
			next_divider = i_reg_wdata[ccm_pkg::BAUD_LSB +: 2];
		end
		unique case (next_divider)
			2'h0: baud_factor = 9'h004;
			2'h1: baud_factor = 9'h010;
			2'h2: baud_factor = 9'h040;
			2'h3: baud_factor = 9'h100;
		endcase
	end

	// Reads are answered one cycle later; the status word ignores writes entirely.
	always_comb begin
		read_word = 32'h0000_0000;
		if (ctl_hit && !i_reg_wr) begin
			read_word[ccm_pkg::BAUD_LSB +: 2]  = state_reg.baud_clock_divider;
			read_word[ccm_pkg::CLOCK_OUTPUT_DIS_BIT] = state_reg.clock_output_disable;
		end else if (sts_hit && !i_reg_wr) begin
			read_word = state_reg.mode_word;
		end
	end

	always_comb begin
		state_next = state_reg;
		// Capture once, on the first edge after power-on reset is released.
		if (!state_reg.captured) begin
			state_next.captured = 1'b1;
			state_next.clock_mode = sampled_mode;
			state_next.mode_word = table_word;
			state_next.factors = decoded;
		end
		// Only the control register accepts writes; mode settings stay as captured.
		if (ctl_write) begin
			state_next.baud_clock_divider = next_divider;
			state_next.clock_output_disable = i_reg_wdata[ccm_pkg::CLOCK_OUTPUT_DIS_BIT];
		end
		state_next.baud_divide_factor = baud_factor;
		state_next.rdata = read_word;
	end

	// Reset loads the power-on defaults; otherwise the next state is taken every edge.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= '0;
			state_reg.baud_clock_divider <= ccm_pkg::BAUD_RESET;
			state_reg.baud_divide_factor <= 9'h010;
			state_reg.clock_output_disable <= ccm_pkg::CLOCK_OUTPUT_DIS_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs come from the state register, except the serial control divide factor, which is the constant SERIAL_CTRL_DF.
	assign o_reg_rdata = state_reg.rdata;
	assign o_mode_valid = state_reg.captured;
	assign o_clock_mode = state_reg.clock_mode;
	assign o_factors = state_reg.factors;
	assign o_serial_ctrl_divide_factor = ccm_pkg::SERIAL_CTRL_DF;
	assign o_baud_divide_factor = state_reg.baud_divide_factor;
	assign o_clock_output_enable = !state_reg.clock_output_disable;

endmodule : ccm_clock_mode_config

// *** testbench/ccm_mode_source.sv ***
// Board model driving the mode pins and reset-word mode bits.
`timescale 1ns/10ps
module ccm_mode_source (
	input  wire logic       i_clock, i_rst,
	input  wire logic [5:0] i_mode,
	output logic      [2:0] o_pins, o_word_bits
);
	logic [5:0] q = 6'h00;
	assign {o_pins, o_word_bits} = q;
	// Pins hold the mode in reset, then invert every cycle.
	always @(posedge i_clock or posedge i_rst) q <= i_rst ? i_mode : ~q;
endmodule : ccm_mode_source

// *** testbench/ccm_clock_mode_config_asserts.sv ***
// Port checker for the clock mode configuration block.
`timescale 1ns/10ps
module ccm_clock_mode_config_asserts (
	input wire logic i_clock, i_rst, i_reg_sel, i_reg_wr, o_mode_valid, o_clock_output_enable,
	input wire logic [2:0]  i_clock_mode_pins, i_reset_word_clock_mode_bits,
	input wire logic [16:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata, o_reg_rdata,
	input wire logic [5:0]  o_clock_mode,
	input wire ccm_pkg::ccm_factors_t o_factors,
	input wire logic [7:0]  o_serial_ctrl_divide_factor,
	input wire logic [8:0]  o_baud_divide_factor
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	wire logic ctl = i_reg_sel && i_reg_addr == 17'h1_0c80;
	wire logic sts = i_reg_sel && i_reg_addr == 17'h1_0c88 && o_mode_valid;
	capture_mode_a: assert property (!o_mode_valid |=> o_mode_valid &&
		o_clock_mode == $past({i_clock_mode_pins, i_reset_word_clock_mode_bits})) else $error("bad capture");
	mode_hold_a: assert property (o_mode_valid |=> $stable(o_clock_mode) && $stable(o_factors))
		else $error("mode moved");
	serial_fixed_a: assert property (o_serial_ctrl_divide_factor == 8'h04) else $error("serial df");
	baud_write_a: assert property (ctl && i_reg_wr |=> $stable(o_factors) &&
		o_baud_divide_factor == 9'h004 << (2 * $past(i_reg_wdata[1:0]))) else $error("baud df");
	clock_output_write_a: assert property (ctl && i_reg_wr |=>
		o_clock_output_enable == !$past(i_reg_wdata[4])) else $error("clock output");
	status_ro_a: assert property (i_reg_sel && i_reg_wr && !ctl |=> $stable(o_baud_divide_factor)
		&& $stable(o_clock_output_enable)) else $error("write not ignored");
	status_read_a: assert property (sts && !i_reg_wr |=>
		o_reg_rdata[7:4] == {1'b0, o_factors.delay_loop_disable, 2'h0}) else $error("status read");
	control_read_a: assert property (ctl && !i_reg_wr |=> o_reg_rdata[31:5] == 27'h0
		&& o_reg_rdata[3:2] == 2'h0 && o_reg_rdata[4] != o_clock_output_enable) else $error("ctl read");
endmodule : ccm_clock_mode_config_asserts
bind ccm_clock_mode_config ccm_clock_mode_config_asserts u_chk (.*);

// *** testbench/ccm_clock_mode_config_bench.sv ***
// Self-checking bench for the clock mode configuration block.
`timescale 1ns/10ps
module ccm_clock_mode_config_bench;
	typedef logic [31:0] ccm_table_t [64];
	logic i_clock = 0, i_rst = 1, sel = 0, wr = 0, en, vld;
	logic [2:0] pins, wbits;
	logic [5:0] m = 6'h3f, mode;
	logic [16:0] addr = 17'h0_0000;
	logic [31:0] wd = 32'h0000_0000, rd, d;
	logic [7:0] sdf;
	logic [8:0] baud;
	ccm_pkg::ccm_factors_t fac;
	int fail_count = 0, num_checks = 0, cyc = 0;
	function automatic logic [31:0] word_of(int k);
		return {4'(k % 4), 4'(5 + k % 3), 4'(1 + k % 5), 4'(k % 3), 4'(k % 6), 4'(5 + k % 11),
			1'b0, k[0], 2'h0, 4'(k % 6)};
	endfunction : word_of
	function automatic ccm_table_t mk_table();
		ccm_table_t t;
		for (int k = 0; k < 64; k++) t[k] = word_of(k) | 32'h0000_00b0;
		return t;
	endfunction : mk_table
	function automatic ccm_pkg::ccm_factors_t fac_of(logic [31:0] w);
		return '{8'(w[31:28]) + 8'h01, 8'(w[27:24]) << 1, 8'(w[23:20]) + 8'h01, 8'(w[19:16]) + 8'h01,
			8'(w[15:12]) + 8'h01, 8'(w[11:8]) << 1, 8'(w[3:0]) + 8'h01, w[6]};
	endfunction : fac_of
	localparam ccm_table_t TABLE = mk_table();
	ccm_mode_source u_src (.i_clock(i_clock), .i_rst(i_rst), .i_mode(m), .o_pins(pins),
		.o_word_bits(wbits));
	ccm_clock_mode_config #(.MODE_TABLE(TABLE)) DUT (.i_clock(i_clock), .i_rst(i_rst),
		.i_clock_mode_pins(pins), .i_reset_word_clock_mode_bits(wbits), .i_reg_sel(sel),
		.i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rd), .o_mode_valid(vld),
		.o_clock_mode(mode), .o_factors(fac), .o_serial_ctrl_divide_factor(sdf),
		.o_baud_divide_factor(baud), .o_clock_output_enable(en));
	task automatic check(string n, logic [63:0] e, logic [63:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : check
	task automatic acc(logic w, logic [16:0] a, logic [31:0] v);
		@(posedge i_clock);
		sel <= 1;
		wr <= w;
		addr <= a;
		wd <= v;
		@(posedge i_clock);
		sel <= 0;
		#1;
	endtask : acc
	task automatic close_out();
		$display("Checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : close_out
	initial forever #2.5 i_clock = ~i_clock;
	always @(posedge i_clock) if (++cyc == 2000) begin
		fail_count++;
		close_out();
	end
	initial begin
		void'($urandom(21656));
		for (int k = 0; k < 4; k++) begin
			if (k > 0) m = 6'($urandom);
			i_rst <= 1;
			repeat (8) @(posedge i_clock);
			check("valid in reset", 0, vld);
			i_rst <= 0;
			repeat (4) @(posedge i_clock);
			#1;
			check("valid", 1, vld);
			check("mode", m, mode);
			check("factors", fac_of(word_of(m)), fac);
			check("baud reset", 16, baud);
			check("clock_output reset", 1, en);
			check("serial", 4, sdf);
			acc(1, 17'h1_0c88, $urandom);
			acc(0, 17'h1_0c88, 0);
			check("status", word_of(m), rd);
			acc(0, 17'h0_0c84, 0);
			check("unmapped", 0, rd);
			for (int c = 0; c < 4; c++) begin
				d = {27'h0, 1'($urandom), 2'h0, 2'(c)};
				acc(1, 17'h1_0c80, d);
				check("baud", 9'h004 << (2 * c), baud);
				check("clock_output", !d[4], en);
				check("factors kept", fac_of(word_of(m)), fac);
				acc(0, 17'h1_0c80, 0);
				check("control", d, rd);
			end
		end
		close_out();
	end
endmodule : ccm_clock_mode_config_bench
